// ### sarl_consts.svh
`ifndef SARL_CONSTS_SVH
`define SARL_CONSTS_SVH
// Register byte offsets
`define SARL_OFF_START     12'h000
`define SARL_OFF_HIGH      12'h004
`define SARL_OFF_LOW       12'h008
`define SARL_OFF_TARGET    12'h00C
`define SARL_OFF_CTRL      12'h010
`define SARL_OFF_MASKCNT   12'h014
`define SARL_OFF_STATUS    12'h018
// Control field positions
`define SARL_CTRL_EN       0
`define SARL_CTRL_ARL      1
`define SARL_CTRL_MSK      2
// Reset values and full compare mask
`define SARL_RST_STEP      16'h0000
`define SARL_RST_START     16'h0000
`define SARL_RST_MASKCNT   4'h0
`define SARL_FULL_MASK     16'hFFFF
// AXI responses
`define SARL_RESP_OKAY     2'h0
`define SARL_RESP_SLVERR   2'h2
`endif

// ### sarl_pkg.sv
package sarl_pkg;
  // Write address and data held in the slave
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } sarl_wr_type;
  // Register bus state
  typedef enum logic [2:0] {
    SARL_IDLE = 3'b001,
    SARL_RESP = 3'b010,
    SARL_RDAT = 3'b100
  } sarl_bus_type;
endpackage : sarl_pkg

// ### sarl_top.sv
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "sarl_consts.svh"
// How it works
// - Auto-reload adds step on each strobe event not coinciding with a restart
// - Reload off: target reads start value
// - Target begins from start value
// - Output toggles at match, target updates on the same edge
// - Level high adds low step, else high
// - Masked step bits do not shift alarm
// - Step registers absent in first instance
// - Alarm when masked low count equals target
// - Mask is ones shifted by count, or zero
// - Target reloads on start write, enable rise, reload off
module sarl_top #(
  parameter bit SECOND_INSTANCE = 1'b1   // Step registers exist only here
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] rtc_count_low,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             strobe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] strobe_start_value;   // Start of the sequence
  logic [15:0] high_phase_step;      // Step added while level low
  logic [15:0] low_phase_step;       // Step added while level high
  logic [15:0] cumulative_target;    // Running alarm target
  logic        channel_enable;       // Channel on
  logic        auto_reload_enable;   // Reload on
  logic        compare_mask_enable;  // Masking on
  logic [3:0]  strobe_mask_counts;   // Mask shift count
  logic        en_q;                 // Enable of previous cycle
  logic        arl_q;                // Reload enable of previous cycle
  logic        event_count_hit;      // Sticky: at least one alarm seen
  logic        wr_have_aw;           // Write address captured
  logic        wr_have_w;            // Write data captured
  sarl_pkg::sarl_wr_type wr_hold;    // Captured write
  sarl_pkg::sarl_bus_type wr_state;  // Write side state

  ////////////////////////////////////////////////////////////////////////////
  // Compare and reload logic
  wire [15:0] cmp_mask   = compare_mask_enable ? (`SARL_FULL_MASK << strobe_mask_counts) : 16'h0000;
  wire        alarm_hit  = channel_enable && (((rtc_count_low ^ cumulative_target) & ~cmp_mask) == 16'h0000);
  wire [15:0] step_sel   = strobe_out ? low_phase_step : high_phase_step;
  wire [15:0] step_eff   = step_sel & ~cmp_mask;
  wire [15:0] target_sum = 16'(cumulative_target + step_eff);
  wire        do_wr      = wr_have_aw && wr_have_w && (wr_state == sarl_pkg::SARL_IDLE);
  wire [3:0]  wr_idx     = wr_hold.addr[5:2];
  wire        wr_lo      = wr_hold.strb[0];
  wire        wr_hi      = wr_hold.strb[1];
  wire        wr_start   = do_wr && (wr_hold.addr == `SARL_OFF_START);
  wire        wr_high    = do_wr && (wr_hold.addr == `SARL_OFF_HIGH) && SECOND_INSTANCE;
  wire        wr_low     = do_wr && (wr_hold.addr == `SARL_OFF_LOW) && SECOND_INSTANCE;
  wire        wr_ctrl    = do_wr && (wr_hold.addr == `SARL_OFF_CTRL) && wr_lo;
  wire        wr_mcnt    = do_wr && (wr_hold.addr == `SARL_OFF_MASKCNT) && wr_lo;
  wire        wr_ok      = (wr_idx <= 4'h6) && (wr_hold.addr[1:0] == 2'b00) && (wr_hold.addr[11:6] == 6'h00);
  wire [15:0] start_next = {wr_hi ? wr_hold.data[15:8] : strobe_start_value[15:8],
                            wr_lo ? wr_hold.data[7:0] : strobe_start_value[7:0]};
  wire        restart    = wr_start || (channel_enable && !en_q) || (!auto_reload_enable && arl_q);

  // Alarm output and target update
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cumulative_target <= `SARL_RST_START;
      strobe_out        <= 1'b0;
      event_count_hit   <= 1'b0;
    end else begin
      if (alarm_hit) begin
        strobe_out      <= ~strobe_out;
        event_count_hit <= 1'b1;
      end
      if (wr_start) begin
        cumulative_target <= start_next;
      end else if (restart || !auto_reload_enable) begin
        cumulative_target <= strobe_start_value;
      end else if (alarm_hit) begin
        cumulative_target <= target_sum;
      end
    end
  end

  // Configuration registers and edge history
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strobe_start_value  <= `SARL_RST_START;
      high_phase_step     <= `SARL_RST_STEP;
      low_phase_step      <= `SARL_RST_STEP;
      channel_enable      <= 1'b0;
      auto_reload_enable  <= 1'b0;
      compare_mask_enable <= 1'b0;
      strobe_mask_counts  <= `SARL_RST_MASKCNT;
      en_q                <= 1'b0;
      arl_q               <= 1'b0;
    end else begin
      en_q  <= channel_enable;
      arl_q <= auto_reload_enable;
      if (wr_start) strobe_start_value <= start_next;
      if (wr_high) begin
        if (wr_lo) high_phase_step[7:0]  <= wr_hold.data[7:0];
        if (wr_hi) high_phase_step[15:8] <= wr_hold.data[15:8];
      end
      if (wr_low) begin
        if (wr_lo) low_phase_step[7:0]  <= wr_hold.data[7:0];
        if (wr_hi) low_phase_step[15:8] <= wr_hold.data[15:8];
      end
      if (wr_ctrl) begin
        channel_enable      <= wr_hold.data[`SARL_CTRL_EN];
        auto_reload_enable  <= wr_hold.data[`SARL_CTRL_ARL];
        compare_mask_enable <= wr_hold.data[`SARL_CTRL_MSK];
      end
      if (wr_mcnt) strobe_mask_counts <= wr_hold.data[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_have_aw    <= 1'b0;
      wr_have_w     <= 1'b0;
      wr_hold       <= '0;
      wr_state      <= sarl_pkg::SARL_IDLE;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SARL_RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      // Capture address
      if (s_axi_awvalid && !wr_have_aw && !s_axi_awready && wr_state == sarl_pkg::SARL_IDLE) begin
        s_axi_awready <= 1'b1;
        wr_have_aw    <= 1'b1;
        wr_hold.addr  <= s_axi_awaddr;
      end
      // Capture data
      if (s_axi_wvalid && !wr_have_w && !s_axi_wready && wr_state == sarl_pkg::SARL_IDLE) begin
        s_axi_wready <= 1'b1;
        wr_have_w    <= 1'b1;
        wr_hold.data <= s_axi_wdata;
        wr_hold.strb <= s_axi_wstrb;
      end
      // Commit and respond
      if (do_wr) begin
        wr_have_aw   <= 1'b0;
        wr_have_w    <= 1'b0;
        wr_state     <= sarl_pkg::SARL_RESP;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `SARL_RESP_OKAY : `SARL_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        wr_state     <= sarl_pkg::SARL_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read side
  wire [15:0] high_rd = SECOND_INSTANCE ? high_phase_step : `SARL_RST_STEP;
  wire [15:0] low_rd  = SECOND_INSTANCE ? low_phase_step : `SARL_RST_STEP;
  logic [31:0] rd_mux;
  logic        rd_err;
  always_comb begin
    rd_err = 1'b0;
    unique case (s_axi_araddr)
      `SARL_OFF_START:   rd_mux = {16'h0000, strobe_start_value};
      `SARL_OFF_HIGH:    rd_mux = {16'h0000, high_rd};
      `SARL_OFF_LOW:     rd_mux = {16'h0000, low_rd};
      `SARL_OFF_TARGET:  rd_mux = {16'h0000, cumulative_target};
      `SARL_OFF_CTRL:    rd_mux = {29'h0, compare_mask_enable, auto_reload_enable, channel_enable};
      `SARL_OFF_MASKCNT: rd_mux = {28'h0, strobe_mask_counts};
      `SARL_OFF_STATUS:  rd_mux = {30'h0, event_count_hit, strobe_out};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b1;
      end
    endcase
  end

  // One read at a time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SARL_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_err ? `SARL_RESP_SLVERR : `SARL_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_toggle;
    @(posedge clk) disable iff (sys_rst) alarm_hit |=> (strobe_out != $past(strobe_out));
  endproperty
  a_toggle: assert property (p_toggle) else $error("strobe did not toggle on alarm");
  property p_reload_add;
    @(posedge clk) disable iff (sys_rst)
      (alarm_hit && auto_reload_enable && arl_q && !restart) |=> (cumulative_target == $past(target_sum));
  endproperty
  a_reload_add: assert property (p_reload_add) else $error("target not stepped");
  property p_no_reload;
    @(posedge clk) disable iff (sys_rst)
      (!auto_reload_enable && !wr_start) |=> cumulative_target == $past(strobe_start_value);
  endproperty
  a_no_reload: assert property (p_no_reload) else $error("target differs from start value");
  property p_start_write;
    @(posedge clk) disable iff (sys_rst) wr_start |=> cumulative_target == strobe_start_value;
  endproperty
  a_start_write: assert property (p_start_write) else $error("start write did not reset target");
  property p_enable_rise;
    @(posedge clk) disable iff (sys_rst)
      (channel_enable && !en_q && !wr_start) |=> cumulative_target == $past(strobe_start_value);
  endproperty
  a_enable_rise: assert property (p_enable_rise) else $error("enable rise did not reset target");
  // Step picked from the level before the toggle, worked out apart from step_sel
  property p_phase_step;
    @(posedge clk) disable iff (sys_rst)
      (alarm_hit && auto_reload_enable && arl_q && !restart) |=>
        cumulative_target == 16'($past(cumulative_target) +
          (($past(strobe_out) ? $past(low_phase_step) : $past(high_phase_step)) & ~$past(cmp_mask)));
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("wrong phase step");
  // Unmasked bits are those below the count: shift them to the top and test for zero
  property p_mask_cmp;
    @(posedge clk) disable iff (sys_rst)
      alarm_hit == (channel_enable &&
        (16'((rtc_count_low ^ cumulative_target) << (compare_mask_enable ? 5'd16 - 5'(strobe_mask_counts) : 5'd0))
         == 16'h0000));
  endproperty
  a_mask_cmp: assert property (p_mask_cmp) else $error("masked match missed");
  // The offset actually added carries no masked bit
  property p_step_mask;
    @(posedge clk) disable iff (sys_rst)
      (alarm_hit && auto_reload_enable && arl_q && !restart) |=>
        (16'(cumulative_target - $past(cumulative_target)) & $past(cmp_mask)) == 16'h0000;
  endproperty
  a_step_mask: assert property (p_step_mask) else $error("masked step bits used");
  property p_mask_off;
    @(posedge clk) disable iff (sys_rst) !compare_mask_enable |-> cmp_mask == 16'h0000;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("mask not zero when off");
  property p_first_inst;
    @(posedge clk) disable iff (sys_rst) !SECOND_INSTANCE |-> (high_rd == `SARL_RST_STEP && low_rd == `SARL_RST_STEP);
  endproperty
  a_first_inst: assert property (p_first_inst) else $error("step visible in first instance");
  // Carry out of bit 15 is dropped in the stored target
  property p_wrap;
    @(posedge clk) disable iff (sys_rst)
      (alarm_hit && auto_reload_enable && arl_q && !restart) |=>
        cumulative_target == 16'(17'($past(cumulative_target)) + 17'($past(step_eff)));
  endproperty
  a_wrap: assert property (p_wrap) else $error("step sum not wrapped");
  c_alarm:  cover property (@(posedge clk) disable iff (sys_rst) alarm_hit && auto_reload_enable);
  c_two:    cover property (@(posedge clk) disable iff (sys_rst) alarm_hit ##[1:200] alarm_hit);
  c_restart: cover property (@(posedge clk) disable iff (sys_rst) !auto_reload_enable && arl_q);
endmodule : sarl_top

// ### sarl_top_tb.sv
`timescale 1ns/10ps
`include "sarl_consts.svh"
module sarl_top_tb;
  logic        clk           = 1'b0;          // Bench clock
  logic        sys_rst       = 1'b1;          // Reset, held at start
  logic [15:0] rtc_count_low = 16'h0000;      // Low RTC count bits
  logic [11:0] s_axi_awaddr  = 12'h000;       // Write address
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h00000000;  // Write data
  logic [3:0]  s_axi_wstrb   = 4'hF;          // All byte lanes unless a test sets fewer
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [11:0] s_axi_araddr  = 12'h000;       // Read address
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, strobe_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int          err_total = 0;                 // Mismatches
  int          checks    = 0;                 // Comparisons
  logic [15:0] tgt, hstep, lstep, msk, s2;    // Model target, steps, mask, start
  logic        lvl;                           // Model output level

  // Clock of 100 ns period
  always #50 clk = ~clk;

  sarl_top #(.SECOND_INSTANCE(1'b1)) i_sarl_top (
    .clk(clk), .sys_rst(sys_rst), .rtc_count_low(rtc_count_low),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .strobe_out(strobe_out));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Next target after one alarm: step picked by level, masked bits dropped
  function automatic logic [15:0] next_tgt(input logic [15:0] t, input logic l, input logic [15:0] m);
    return 16'(t + ((l ? lstep : hstep) & ~m));
  endfunction : next_tgt

  // A used-up wait bound ends the run
  task automatic tmo(input int n);
    if (n >= 50) begin
      err_total++;
      $display("Error bus wait expected answer seen none");
      finish_test();
    end
  endtask : tmo

  ////////////////////////////////////////////////////////////////////////////
  // Bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
    int   n;
    logic ah;
    logic wh;
    n  = 0;
    ah = 1'b1;
    wh = 1'b1;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while ((ah || wh) && n < 50) begin
      @(posedge clk);
      n++;
      if (ah && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        ah = 1'b0;
      end
      if (wh && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        wh = 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    s_axi_bready <= 1'b0;
    tmo(n);
    chk($sformatf("bresp %h", a), 32'(s_axi_bresp), 32'(er));
  endtask : wr

  // Bus read: request held until the answer is sampled
  task automatic rd(input logic [11:0] a, input logic [15:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b0;
    tmo(n);
    chk($sformatf("rdata %h", a), s_axi_rdata, {16'h0000, ed});
    chk($sformatf("rresp %h", a), 32'(s_axi_rresp), 32'(er));
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // One alarm: count meets target for one cycle, then parks off target
  task automatic fire();
    @(posedge clk);
    rtc_count_low <= tgt ^ (16'($urandom) & msk);
    @(posedge clk);
    tgt = next_tgt(tgt, lvl, msk);
    lvl = ~lvl;
    rtc_count_low <= tgt + 16'h0001;
    repeat (3) @(posedge clk);
    chk("strobe_out", 32'(strobe_out), 32'(lvl));
    rd(`SARL_OFF_TARGET, tgt, `SARL_RESP_OKAY);
  endtask : fire

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(4407));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 7; a++) rd(12'(4 * a), 16'h0000, `SARL_RESP_OKAY);
    rd(12'h01C, 16'h0000, `SARL_RESP_SLVERR);
    rd(12'h002, 16'h0000, `SARL_RESP_SLVERR);
    wr(12'h01C, 16'h1234, `SARL_RESP_SLVERR);
    hstep = 16'($urandom);
    lstep = 16'($urandom);
    wr(`SARL_OFF_HIGH, hstep, `SARL_RESP_OKAY);
    wr(`SARL_OFF_LOW, lstep, `SARL_RESP_OKAY);
    rd(`SARL_OFF_HIGH, hstep, `SARL_RESP_OKAY);
    rd(`SARL_OFF_LOW, lstep, `SARL_RESP_OKAY);
    // Upper byte lane only: the low byte of the step must survive
    s2 = 16'($urandom);
    s_axi_wstrb <= 4'h2;
    wr(`SARL_OFF_HIGH, s2, `SARL_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    hstep = {s2[15:8], hstep[7:0]};
    rd(`SARL_OFF_HIGH, hstep, `SARL_RESP_OKAY);
    // Start near the top so the sum wraps
    tgt = {8'hFF, 8'($urandom)};
    rtc_count_low <= tgt + 16'h0001;
    wr(`SARL_OFF_START, tgt, `SARL_RESP_OKAY);
    rd(`SARL_OFF_TARGET, tgt, `SARL_RESP_OKAY);
    lvl = 1'b0;
    msk = 16'h0000;
    wr(`SARL_OFF_MASKCNT, 16'h0008, `SARL_RESP_OKAY);
    wr(`SARL_OFF_CTRL, 16'h0003, `SARL_RESP_OKAY);
    rd(`SARL_OFF_TARGET, tgt, `SARL_RESP_OKAY);
    repeat (4) fire();
    // Mask on: upper byte ignored in compare and step
    msk = 16'hFF00;
    wr(`SARL_OFF_CTRL, 16'h0007, `SARL_RESP_OKAY);
    repeat (6) fire();
    rd(`SARL_OFF_STATUS, {14'h0000, 1'b1, lvl}, `SARL_RESP_OKAY);
    msk = 16'h0000;
    wr(`SARL_OFF_CTRL, 16'h0003, `SARL_RESP_OKAY);
    // Restart events: start write, reload off
    s2 = 16'($urandom);
    rtc_count_low <= s2 + 16'h0001;
    wr(`SARL_OFF_START, s2, `SARL_RESP_OKAY);
    tgt = s2;
    rd(`SARL_OFF_TARGET, tgt, `SARL_RESP_OKAY);
    fire();
    wr(`SARL_OFF_CTRL, 16'h0001, `SARL_RESP_OKAY);
    tgt = s2;
    rd(`SARL_OFF_TARGET, tgt, `SARL_RESP_OKAY);
    wr(`SARL_OFF_CTRL, 16'h0003, `SARL_RESP_OKAY);
    fire();
    // Disabled channel must ignore a match
    wr(`SARL_OFF_CTRL, 16'h0002, `SARL_RESP_OKAY);
    rtc_count_low <= tgt;
    repeat (3) @(posedge clk);
    chk("strobe_out off", 32'(strobe_out), 32'(lvl));
    rtc_count_low <= s2 + 16'h0001;
    wr(`SARL_OFF_CTRL, 16'h0003, `SARL_RESP_OKAY);
    tgt = s2;
    rd(`SARL_OFF_TARGET, tgt, `SARL_RESP_OKAY);
    finish_test();
  end
endmodule : sarl_top_tb
